/* hw/ttbc_pkg.sv */
// ****************************************************************
// Shared constants of the trace trigger and break controller.
// ****************************************************************
package ttbc_pkg;

	// ****************************************************************
	// Register byte offsets on the AXI4-Lite bus.
	// ****************************************************************
	localparam logic [7:0] debugControlRegOffset = 8'h00; // Enable, arm, break setup.
	localparam logic [7:0] triggerSetupRegOffset = 8'h04; // Qualify, begin, trigger mode.
	localparam logic [7:0] debugStatusRegOffset  = 8'h08; // Armed and match flags.
	localparam logic [7:0] traceCountRegOffset   = 8'h0c; // Number of valid trace words.
	localparam logic [7:0] traceDataRegOffset    = 8'h10; // Trace word readout.

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int ctlEnableBit      = 0; // Module enable.
	localparam int ctlArmBit         = 1; // Arm control.
	localparam int ctlBreakEnableBit = 2; // CPU break enable.
	localparam int ctlTagBit         = 3; // Tag-type when set, force-type when clear.
	localparam int trgQualifyBit     = 7; // Opcode qualify select.
	localparam int trgBeginBit       = 6; // Begin-type run when set.
	localparam int stsArmedBit       = 0; // Armed status flag.
	localparam int stsMatchABit      = 1; // Match flag A.
	localparam int stsMatchBBit      = 2; // Match flag B.
	localparam int stsMatchCBit      = 3; // Match flag C.

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [3:0] debugControlReset = 4'h0; // Everything off.
	localparam logic [7:0] triggerSetupReset = 8'h00; // End-type, A-only.

	// ****************************************************************
	// Trigger mode codes.
	// ****************************************************************
	localparam logic [3:0] modeAOnly      = 4'h0; // A only.
	localparam logic [3:0] modeAOrB       = 4'h1; // A or B.
	localparam logic [3:0] modeAThenB     = 4'h2; // A then B.
	localparam logic [3:0] modeEventB     = 4'h3; // Event only B.
	localparam logic [3:0] modeAThenEvB   = 4'h4; // A then event only B.
	localparam logic [3:0] modeAAndB      = 4'h5; // A and B, full mode.
	localparam logic [3:0] modeAAndNotB   = 4'h6; // A and not B, full mode.
	localparam logic [3:0] modeInsideRng  = 4'h7; // Inside range.
	localparam logic [3:0] modeOutsideRng = 4'h8; // Outside range.

	// ****************************************************************
	// Trace buffer and bus answers.
	// ****************************************************************
	localparam int         traceDepth  = 8;     // Words held by the trace buffer.
	localparam logic [1:0] respOkay    = 2'h0;  // AXI OKAY.
	localparam logic [1:0] respSlvErr  = 2'h2;  // AXI SLVERR for unmapped offsets.
	localparam logic [15:0] cofBackStep = 16'h0002; // Branch source is two bytes back.

endpackage

/* hw/ttbc_trigger_break_control.sv */
// Overview of operation
// (RL1) Nothing works unless module enable is set.
// (RL2) Break enable gates requests; tag bit picks type.
// (RL3) Debugger writes 0x81 or 0x01 for breakpoints.
// (RL4) Comparator C only breaks, never triggers trace.
// (RL5) Qualify select requires opcode tracking confirmation.
// (RL6) End-type: qualified match stops capture, breaks.
// (RL7) Begin-type: match starts capture, full breaks.
// (RL8) Debugger keeps tag and qualify select agreeing.
// (RL9) Begin: store after trigger until eight words.
// (RL10) End: store until trigger, oldest dropped.
// (RL11) Debugger arms with enable and arm set.
// (RL12) Arm cleared at trigger or buffer full.
// (RL13) Any reset clears arm and armed flag.
// (RL14) Armed flag clears on arm write zero, disable.
// (RL15) Nine modes set flags; arming clears flags. A match in the cycle of a re-arm still sets them.
// (RL16) Capture flow addresses, or data in event modes.
// (RL17) A-only, A-or-B, event-B set own flags.
// (RL18) Then-modes ignore B until A matched.
// (RL19) Event modes always run as begin-type.
// (RL20) Full modes set both flags on coincidence.
// (RL21) Full modes tagged end-break use A only.
// (RL22) Inside range sets both flags together only.
// (RL23) Mode code 0x0 is A-only, 0x1 A-or-B.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module ttbc_trigger_break_control #(
	parameter int addrWidth = 16,
	parameter int dataWidth = 8
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [addrWidth-1:0] coreAddr,
	input  wire logic [dataWidth-1:0] coreData,
	input  wire logic [1:0]           coreCof,
	input  wire logic                 compMatchA,
	input  wire logic                 compMatchB,
	input  wire logic                 compMatchC,
	input  wire logic                 opcodeMatchA,
	input  wire logic                 opcodeMatchB,
	output logic                      breakRequest,
	output logic                      breakTag
);

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic                 moduleEnable;         // Module enable bit.
	logic                 armControl;           // Arm control bit.
	logic                 cpuBreakEnable;       // CPU break enable bit.
	logic                 breakTagSel;          // Tag-type when set.
	logic                 opcodeQualifySelect;  // Opcode qualify select bit.
	logic                 beginSel;             // Begin-type run bit.
	logic [3:0]           triggerMode;          // Trigger mode field.
	logic                 armedStatusFlag;      // Armed status flag.
	logic                 matchAFlag;           // Match flag A.
	logic                 matchBFlag;           // Match flag B.
	logic                 matchCFlag;           // Match flag C.
	logic                 aSeen;                // A satisfied in a then-mode.
	logic                 capturing;            // Begin-type run past its trigger.
	logic [addrWidth-1:0] prevAddr;             // Address of the previous cycle.
	logic [15:0]          traceBuf [ttbc_pkg::traceDepth]; // Oldest word at index zero.
	logic [3:0]           traceCount;           // Valid words, zero to eight.
	logic [2:0]           readIdx;              // Next word for readout.

	// Maps a byte address to a register select; shared by the read and write paths.
	function automatic logic [2:0] regSel(input logic [7:0] addr);
		logic [2:0] sel;
		unique case (addr)
			ttbc_pkg::debugControlRegOffset: sel = 3'h0;
			ttbc_pkg::triggerSetupRegOffset: sel = 3'h1;
			ttbc_pkg::debugStatusRegOffset:  sel = 3'h2;
			ttbc_pkg::traceCountRegOffset:   sel = 3'h3;
			ttbc_pkg::traceDataRegOffset:    sel = 3'h4;
			default:                         sel = 3'h7;
		endcase
		return sel;
	endfunction

	// ****************************************************************
	// Bus handshake decode.
	// ****************************************************************
	logic       writeTake;   // Address and data taken together this cycle.
	logic       readTake;    // Read address taken this cycle.
	logic [2:0] writeSel;    // Register addressed by the write.
	logic [2:0] readSel;     // Register addressed by the read.
	logic       ctlWrite;    // Byte 0 write to the control register.
	logic       trgWrite;    // Byte 0 write to the trigger setup register.
	logic       armRequest;  // Write that sets enable and arm together.
	// Both write channels are waited for so that one response covers both.
	assign writeTake  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
	assign readTake   = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
	assign writeSel   = regSel(s_axi_awaddr);
	assign readSel    = regSel(s_axi_araddr);
	assign ctlWrite   = writeTake & s_axi_wstrb[0] & (writeSel == 3'h0);
	assign trgWrite   = writeTake & s_axi_wstrb[0] & (writeSel == 3'h1);
	assign armRequest = ctlWrite & s_axi_wdata[ttbc_pkg::ctlEnableBit]
		& s_axi_wdata[ttbc_pkg::ctlArmBit]; // [RL11]

	// ****************************************************************
	// Trigger qualification.
	// ****************************************************************
	logic eventOnly;   // Event-only modes.
	logic fullMode;    // Address-and-data modes.
	logic beginRun;    // Effective begin-type run.
	logic active;      // Enabled and armed.
	logic qualA;       // Comparator A after qualification.
	logic qualB;       // Comparator B after qualification.
	logic setA;        // Flag A set this cycle.
	logic setB;        // Flag B set this cycle.
	logic trigHit;     // Trigger condition met this cycle.
	logic storeNow;    // A word enters the trace buffer.
	logic [15:0] storeWord; // The word to enter.
	logic endTrig;     // End-type run ends.
	logic fillDone;    // Begin-type run fills its last word.
	logic brkEvent;    // Trace-driven break event.
	assign eventOnly = (triggerMode == ttbc_pkg::modeEventB)
		| (triggerMode == ttbc_pkg::modeAThenEvB);
	assign fullMode  = (triggerMode == ttbc_pkg::modeAAndB)
		| (triggerMode == ttbc_pkg::modeAAndNotB);
	assign beginRun  = beginSel | eventOnly; // [RL19]
	assign active    = moduleEnable & armedStatusFlag; // [RL1]
	// Opcode tracking confirms execution; event modes and the data compare take the bare match.
	assign qualA = (opcodeQualifySelect & ~eventOnly) ? opcodeMatchA : compMatchA; // [RL5]
	assign qualB = (opcodeQualifySelect & ~eventOnly & ~fullMode) ? opcodeMatchB
		: compMatchB; // [RL5]
	// Flag setting per mode; comparator C never enters here.
	always_comb begin // [RL4]
		setA    = 1'b0;
		setB    = 1'b0;
		trigHit = 1'b0;
		unique case (triggerMode)
			ttbc_pkg::modeAOnly: begin // [RL17] [RL23]
				setA    = qualA;
				trigHit = qualA;
			end
			ttbc_pkg::modeAOrB, ttbc_pkg::modeOutsideRng: begin // [RL17] [RL23]
				setA    = qualA;
				setB    = qualB;
				trigHit = qualA | qualB;
			end
			ttbc_pkg::modeAThenB, ttbc_pkg::modeAThenEvB: begin // [RL18]
				setA    = qualA;
				setB    = qualB & aSeen;
				trigHit = qualB & aSeen;
			end
			ttbc_pkg::modeEventB: begin // [RL17]
				setB    = qualB;
				trigHit = qualB;
			end
			ttbc_pkg::modeAAndB, ttbc_pkg::modeInsideRng: begin // [RL20] [RL22]
				setA    = qualA & qualB;
				setB    = qualA & qualB;
				trigHit = qualA & qualB;
			end
			ttbc_pkg::modeAAndNotB: begin // [RL20]
				setA    = qualA & ~qualB;
				setB    = qualA & ~qualB;
				trigHit = qualA & ~qualB;
			end
			default: trigHit = 1'b0; // Unused codes set nothing.
		endcase
	end
	// Event modes store the data byte at the B match; others store flow addresses.
	always_comb begin // [RL16]
		storeWord = 16'h0000;
		if (eventOnly) begin
			storeWord[dataWidth-1:0] = coreData;
		end else if (coreCof[1]) begin
			storeWord[addrWidth-1:0] = coreAddr;
		end else begin
			storeWord[addrWidth-1:0] = prevAddr - ttbc_pkg::cofBackStep[addrWidth-1:0];
		end
	end
	// End runs store all along; begin runs only from the trigger on.
	assign storeNow = active & (eventOnly ? (setB & (beginRun & trigHit | capturing))
		: ((coreCof != 2'b00) & (~beginRun | capturing | trigHit))); // [RL9] [RL10]
	assign endTrig  = active & ~beginRun & trigHit; // [RL6]
	assign fillDone = active & beginRun & storeNow
		& (traceCount == 4'(ttbc_pkg::traceDepth - 1)); // [RL7] [RL9]
	// Tagged breaks in full end runs come from comparator A alone.
	assign brkEvent = (fullMode & breakTagSel & ~beginRun) ? (active & qualA)
		: (endTrig | fillDone); // [RL21] [RL6] [RL7]

	// ****************************************************************
	// Control register and arming.
	// ****************************************************************
	// The async reset also ends any end-type run in progress.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin // [RL13]
			{breakTagSel, cpuBreakEnable, armControl, moduleEnable} <= ttbc_pkg::debugControlReset;
		end else if (ctlWrite) begin
			moduleEnable   <= s_axi_wdata[ttbc_pkg::ctlEnableBit];
			armControl     <= s_axi_wdata[ttbc_pkg::ctlArmBit];
			cpuBreakEnable <= s_axi_wdata[ttbc_pkg::ctlBreakEnableBit];
			breakTagSel    <= s_axi_wdata[ttbc_pkg::ctlTagBit];
		end else if (endTrig | fillDone) begin
			armControl <= 1'b0; // [RL12]
		end
	end
	// Armed flag follows an arm request and falls on trigger, fill, disarm or disable.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin // [RL13]
			armedStatusFlag <= 1'b0;
		end else if (armRequest) begin
			armedStatusFlag <= 1'b1;
		end else if ((ctlWrite & ~s_axi_wdata[ttbc_pkg::ctlArmBit]) | ~moduleEnable) begin
			armedStatusFlag <= 1'b0; // [RL14]
		end else if (endTrig | fillDone) begin
			armedStatusFlag <= 1'b0; // [RL12]
		end
	end
	// Trigger setup register.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			{opcodeQualifySelect, beginSel} <= ttbc_pkg::triggerSetupReset[7:6];
			triggerMode <= ttbc_pkg::triggerSetupReset[3:0];
		end else if (trgWrite) begin
			opcodeQualifySelect <= s_axi_wdata[ttbc_pkg::trgQualifyBit];
			beginSel            <= s_axi_wdata[ttbc_pkg::trgBeginBit];
			triggerMode         <= s_axi_wdata[3:0];
		end
	end

	// ****************************************************************
	// Match flags and run progress.
	// ****************************************************************
	// Arming clears the flags, but a match in the cycle of a re-arm still sets them.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			{matchAFlag, matchBFlag, matchCFlag, aSeen, capturing} <= 5'h00;
		end else if (armRequest) begin
			{matchAFlag, matchBFlag, matchCFlag} <= {setA, setB, compMatchC} & {3{active}};
			{aSeen, capturing} <= 2'b00; // [RL15]
		end else if (active) begin
			matchAFlag <= matchAFlag | setA; // [RL15]
			matchBFlag <= matchBFlag | setB; // [RL15]
			matchCFlag <= matchCFlag | compMatchC;
			aSeen      <= aSeen | qualA; // [RL18]
			capturing  <= capturing | (beginRun & trigHit & ~fillDone); // [RL7]
		end
	end
	// Previous address feeds the branch-source computation.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prevAddr <= '0;
		end else begin
			prevAddr <= coreAddr;
		end
	end

	// ****************************************************************
	// Trace buffer.
	// ****************************************************************
	// A shift keeps the oldest word at index zero; a full end run drops it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			traceCount <= 4'h0;
			for (int i = 0; i < ttbc_pkg::traceDepth; i++) begin
				traceBuf[i] <= 16'h0000;
			end
		end else if (armRequest) begin
			traceCount <= 4'h0;
		end else if (storeNow) begin
			if (traceCount == 4'(ttbc_pkg::traceDepth)) begin
				for (int i = 0; i < ttbc_pkg::traceDepth - 1; i++) begin // [RL10]
					traceBuf[i] <= traceBuf[i+1];
				end
				traceBuf[ttbc_pkg::traceDepth-1] <= storeWord;
			end else begin
				traceBuf[traceCount[2:0]] <= storeWord;
				traceCount <= traceCount + 4'h1;
			end
		end
	end
	// Readout advances only while disarmed; an armed read would lose entries.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			readIdx <= 3'h0;
		end else if (armRequest) begin
			readIdx <= 3'h0;
		end else if (readTake & (readSel == 3'h4) & ~armedStatusFlag) begin
			readIdx <= readIdx + 3'h1;
		end
	end

	// ****************************************************************
	// CPU break request.
	// ****************************************************************
	// Comparator C breaks on its own; A and B break through the run.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			breakRequest <= 1'b0;
			breakTag     <= 1'b0;
		end else begin
			breakRequest <= moduleEnable & cpuBreakEnable
				& (compMatchC | brkEvent); // [RL1] [RL2] [RL4]
			breakTag     <= breakTagSel; // [RL2]
		end
	end

	// ****************************************************************
	// AXI4-Lite slave.
	// ****************************************************************
	// Write channel: ready pulses once, response rises at the same edge.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ttbc_pkg::respOkay;
		end else begin
			s_axi_awready <= writeTake;
			s_axi_wready  <= writeTake;
			if (writeTake) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (writeSel == 3'h7) ? ttbc_pkg::respSlvErr : ttbc_pkg::respOkay;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Read channel: data captured at the taking edge, held until rready.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= ttbc_pkg::respOkay;
		end else begin
			s_axi_arready <= readTake;
			if (readTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= ttbc_pkg::respOkay;
				s_axi_rdata  <= 32'h00000000;
				unique case (readSel)
					3'h0: s_axi_rdata[3:0] <= {breakTagSel, cpuBreakEnable, armControl, moduleEnable};
					3'h1: s_axi_rdata[7:0] <= {opcodeQualifySelect, beginSel, 2'b00, triggerMode};
					3'h2: s_axi_rdata[3:0] <= {matchCFlag, matchBFlag, matchAFlag, armedStatusFlag};
					3'h3: s_axi_rdata[3:0] <= traceCount;
					3'h4: s_axi_rdata[15:0] <= armedStatusFlag ? traceBuf[0] : traceBuf[readIdx];
					default: s_axi_rresp <= ttbc_pkg::respSlvErr;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking dc @(posedge clock); endclocking
	default disable iff (rst);
	a_break_needs_enable: assert property ( // [RL1]
		breakRequest |-> $past(moduleEnable)) else $error("Break while module disabled.");
	a_break_gate_off: assert property ( // [RL2]
		!cpuBreakEnable ##1 !$past(ctlWrite) |-> !breakRequest) else $error("Break while gated.");
	a_cbreak_direct: assert property ( // [RL4]
		moduleEnable && cpuBreakEnable && compMatchC |=> breakRequest)
		else $error("Comparator C break missing.");
	a_end_disarms: assert property ( // [RL6]
		endTrig && !ctlWrite |=> !armedStatusFlag && !armControl) else $error("End run stays armed.");
	a_fill_disarms: assert property ( // [RL12]
		fillDone && !ctlWrite |=> !armedStatusFlag && traceCount == 4'h8)
		else $error("Begin run did not finish at eight.");
	a_count_bound: assert property ( // [RL10]
		traceCount <= 4'h8) else $error("Trace count above depth.");
	a_begin_no_early: assert property ( // [RL9]
		active && beginRun && !capturing && !trigHit && !armRequest |=> $stable(traceCount))
		else $error("Begin run stored before trigger.");
	a_disable_clears: assert property ( // [RL14]
		!moduleEnable && !armRequest |=> !armedStatusFlag) else $error("Armed while disabled.");
	a_arm_clears_flags: assert property ( // [RL15]
		armRequest |=> armedStatusFlag && (matchAFlag || matchBFlag || matchCFlag)
			== $past(active && (setA || setB || compMatchC)))
		else $error("Arming left flags set.");
	a_full_both_flags: assert property ( // [RL20]
		active && fullMode && !armRequest |=> matchAFlag == matchBFlag || $past(matchAFlag != matchBFlag))
		else $error("Full mode set one flag.");
	a_then_b_wait: assert property ( // [RL18]
		active && triggerMode == ttbc_pkg::modeAThenB && !aSeen |-> !setB)
		else $error("B counted before A.");

endmodule

/* bench/ttbc_core_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Core model: loops a short program and reports comparator hits.
// ****************************************************************
module ttbc_core_model (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [15:0] cmpA,
	input  wire logic [15:0] cmpB,
	input  wire logic [15:0] cmpC,
	output logic [15:0]      coreAddr,
	output logic [7:0]       coreData,
	output logic [1:0]       coreCof,
	output logic             compMatchA,
	output logic             compMatchB,
	output logic             compMatchC,
	output logic             opcodeMatchA,
	output logic             opcodeMatchB
);
	int         seed = 29; // Fixed seed for the data bus.
	logic [1:0] trackA;    // Opcode tracking lag for A.
	logic [1:0] trackB;    // Opcode tracking lag for B.
	// The loop wraps every 16 fetches, so any address below 16 recurs.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreAddr <= 16'h0000;
			coreData <= 8'h00;
			trackA <= 2'h0;
			trackB <= 2'h0;
		end else begin
			coreAddr <= (coreAddr + 16'h0001) & 16'h000f;
			coreData <= 8'($random(seed));
			trackA <= {trackA[0], compMatchA};
			trackB <= {trackB[0], compMatchB};
		end
	end
	// A jump destination every fourth fetch; execution is confirmed two cycles late.
	assign coreCof = {coreAddr[1:0] == 2'h3, 1'b0};
	assign compMatchA = coreAddr == cmpA;
	assign compMatchB = coreAddr == cmpB;
	assign compMatchC = coreAddr == cmpC;
	assign opcodeMatchA = trackA[1];
	assign opcodeMatchB = trackB[1];
endmodule

/* bench/trace_trigger_break_control_tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench: bus master, read monitor and scenarios.
// ****************************************************************
module trace_trigger_break_control_tb;
	logic        clock = 1'b0, rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, coreCof;
	logic [15:0] cmpA = 16'h00ff, cmpB = 16'h00ff, cmpC = 16'h00ff, coreAddr;
	logic [7:0]  coreData;
	logic        compMatchA, compMatchB, compMatchC, opcodeMatchA, opcodeMatchB;
	logic        breakRequest, breakTag;
	logic [33:0] expQ[$]; // Expected {rresp, rdata} of reads in flight.
	int          failures = 0, cmpCount = 0;
	ttbc_trigger_break_control dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .coreAddr, .coreData, .coreCof, .compMatchA, .compMatchB,
		.compMatchC, .opcodeMatchA, .opcodeMatchB, .breakRequest, .breakTag);
	ttbc_core_model core (.clock, .rst, .cmpA, .cmpB, .cmpC, .coreAddr, .coreData, .coreCof,
		.compMatchA, .compMatchB, .compMatchC, .opcodeMatchA, .opcodeMatchB);
	initial begin
		forever #2.5 clock = ~clock;
	end
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		cmpCount++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	// Rready stays high, so each read answer stands one cycle at this negedge.
	always @(negedge clock) begin
		if (s_axi_rvalid === 1'b1) begin
			check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
		end
	end
	// One bus cycle; valids are held until the edge after the answer edge, then released.
	task automatic axi(input logic rd, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] e);
		int n;
		n = 0;
		@(posedge clock);
		if (rd) begin
			expQ.push_back(e);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
		end else begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
		end
		do begin
			@(negedge clock);
			n++;
		end while ((rd ? s_axi_rvalid : s_axi_bvalid) !== 1'b1 && n < 50);
		if (!rd) check({32'h0, s_axi_bresp}, e);
		check({33'h0, rd ? s_axi_arready : s_axi_awready & s_axi_wready}, 34'h1);
		@(posedge clock);
		s_axi_arvalid <= 1'b0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		if (n >= 50) begin
			failures++;
			complete_run();
		end
	endtask
	// Watches a window for a break request; a missing one ends the run.
	task automatic waitBreak(input logic want, input logic wantTag);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (breakRequest !== 1'b1 && n < 100);
		check({33'h0, breakRequest}, {33'h0, want});
		if (want) check({33'h0, breakTag}, {33'h0, wantTag});
		if (want && n >= 100) complete_run();
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		axi(1'b1, 8'h00, 32'h0, 34'h0);
		axi(1'b1, 8'h20, 32'h0, {2'h2, 32'h0});
		axi(1'b0, 8'h20, 32'h3, 34'h2);
		$display("test bus done");
		cmpC <= 16'h0009;
		axi(1'b0, 8'h00, 32'h5, 34'h0);
		waitBreak(1'b1, 1'b0);
		axi(1'b1, 8'h08, 32'h0, 34'h0);
		axi(1'b0, 8'h00, 32'h1, 34'h0);
		waitBreak(1'b0, 1'b0);
		$display("test comparator c done");
		cmpC <= 16'h00ff;
		cmpA <= 16'h0002;
		axi(1'b0, 8'h04, 32'h40, 34'h0);
		axi(1'b0, 8'h00, 32'h7, 34'h0);
		waitBreak(1'b1, 1'b0);
		axi(1'b1, 8'h0c, 32'h0, 34'h8);
		axi(1'b1, 8'h00, 32'h0, 34'h5);
		axi(1'b1, 8'h08, 32'h0, 34'h2);
		axi(1'b1, 8'h10, 32'h0, 34'h3);
		axi(1'b1, 8'h10, 32'h0, 34'h7);
		$display("test begin run done");
		cmpA <= 16'h00ff;
		axi(1'b0, 8'h04, 32'h0, 34'h0);
		axi(1'b0, 8'h00, 32'h3, 34'h0);
		axi(1'b1, 8'h08, 32'h0, 34'h1);
		axi(1'b0, 8'h00, 32'h1, 34'h0);
		axi(1'b1, 8'h08, 32'h0, 34'h0);
		axi(1'b0, 8'h00, 32'h3, 34'h0);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		axi(1'b1, 8'h00, 32'h0, 34'h0);
		$display("test arming done");
		cmpB <= 16'h0006;
		axi(1'b0, 8'h04, 32'h81, 34'h0);
		axi(1'b0, 8'h00, 32'hf, 34'h0);
		waitBreak(1'b1, 1'b1);
		axi(1'b1, 8'h08, 32'h0, 34'h4);
		axi(1'b1, 8'h00, 32'h0, 34'hd);
		$display("test breakpoint done");
		cmpA <= 16'h0006;
		cmpB <= 16'h0002;
		axi(1'b0, 8'h04, 32'h2, 34'h0);
		axi(1'b0, 8'h00, 32'h7, 34'h0);
		waitBreak(1'b1, 1'b0);
		axi(1'b1, 8'h08, 32'h0, 34'h6);
		$display("test a then b done");
		complete_run();
	end
endmodule
